// file: design/tcc_top.sv
// timer control block: counter, channel flags, channel-7 override, AHB regs
`timescale 1ns/1ps
`include "tcc_defs.svh"

// Behaviour
// - mask bit 0..6 set on output-compare channel makes its pin output
// - channel 7 compare wins over simultaneous channel 0..6 compare action
// - channel 7 compare drives masked channel outputs to override data bits
// - channel 7 compare copies masked override data into port data
// - main counter is 16 bits and counts up
// - counter writes ignored unless test mode input is 1
// - counter write does not realign prescaler; first period may differ
// - run enable bit 7 stops whole timer when 0, runs when 1
// - inactive timer gives no divide-by-64 clock to pulse accumulator
// - stop-in-wait bit 6 halts timer and accumulator in wait mode
// - stop-in-freeze bit 5 halts counter in freeze; accumulator runs
// - fast clear bit 4 at 0 leaves only normal flag clearing
// - fast clear: read capture or write compare channel clears its flag
// - fast clear: any counter byte access clears overflow flag
// - fast clear: pulse count access clears both accumulator flags
// - channel select 1 means output compare, 0 input capture

module tcc_top
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // chip mode levels, same clock
   input  wire logic        test_mode,
   input  wire logic        wait_mode,
   input  wire logic        freeze_mode,
   // timer port pins
   input  wire logic [7:0]  tim_pin_in,
   output logic [7:0]       tim_pin_out,
   output logic [7:0]       tim_pin_oe,
   // pulse accumulator side
   input  wire logic [15:0] pa_count,
   input  wire logic        pa_overflow_evt,
   input  wire logic        pa_input_evt,
   output logic             pa_div64_tick,
   output logic             pa_halt,
   // interrupt
   output logic             timer_irq
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   tcc_pkg::tcc_chan_t  channel_function_select_q;
   tcc_pkg::tcc_chan_t  ch7_override_mask_q;
   tcc_pkg::tcc_chan_t  ch7_override_data_q;
   tcc_pkg::tcc_count_t main_counter_q;
   logic [3:0]          ctrl1_q;              // bits 7:4 of control one
   tcc_pkg::tcc_chan_t  channel_event_flag_q;
   logic                counter_overflow_flag_q;
   logic                pulse_accum_overflow_flag_q;
   logic                pulse_accum_input_flag_q;
   tcc_pkg::tcc_stat_t  irq_enable_q;
   tcc_pkg::tcc_chan_t  port_data_q;
   tcc_pkg::tcc_count_t chan_val_q [8];
   logic [31:0]         hrdata_q;

   logic                timer_run_enable;
   logic                stop_in_wait;
   logic                stop_in_freeze;
   logic                fast_flag_clear;

   assign timer_run_enable = ctrl1_q[3];
   assign stop_in_wait     = ctrl1_q[2];
   assign stop_in_freeze   = ctrl1_q[1];
   assign fast_flag_clear  = ctrl1_q[0];

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   logic                addr_take;
   logic                rd_take;
   tcc_pkg::tcc_idx_t   addr_idx;
   logic                dp_wr_q;
   tcc_pkg::tcc_idx_t   dp_idx_q;
   logic                wr_now;

   assign addr_take = hsel && hready && htrans[1];
   assign rd_take   = addr_take && !hwrite;
   assign addr_idx  = haddr[7:2];
   assign wr_now    = dp_wr_q;

   // zero wait states, every answer is OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // write data arrives one cycle after the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_q  <= 1'b0;
         dp_idx_q <= 6'h00;
      end
      else
      begin
         dp_wr_q  <= addr_take && hwrite;
         dp_idx_q <= addr_idx;
      end
   end

   function automatic logic wr_at(input tcc_pkg::tcc_idx_t idx);
      wr_at = wr_now && (dp_idx_q == idx);
   endfunction

   // ------------------------------------------------------------
   // run control and prescaler
   // ------------------------------------------------------------
   logic tim_active;
   logic cnt_run;

   assign tim_active = timer_run_enable
                       && !(wait_mode && stop_in_wait);
   assign cnt_run    = tim_active
                       && !(freeze_mode && stop_in_freeze);
   // freeze leaves the accumulator alone, wait does not
   assign pa_halt    = !timer_run_enable
                       || (wait_mode && stop_in_wait);

   tcc_prescaler u_pre
   (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .run        (tim_active),
      .div64_tick (pa_div64_tick)
   );

   // ------------------------------------------------------------
   // pin input synchronisers and edge detect
   // ------------------------------------------------------------
   tcc_pkg::tcc_chan_t pin_s1_q;
   tcc_pkg::tcc_chan_t pin_s2_q;
   tcc_pkg::tcc_chan_t pin_prev_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_s1_q   <= 8'h00;
         pin_s2_q   <= 8'h00;
         pin_prev_q <= 8'h00;
      end
      else
      begin
         pin_s1_q   <= tim_pin_in;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // ------------------------------------------------------------
   // main counter
   // ------------------------------------------------------------
   // the prescaler is not restarted by a write, so the first
   // divided period after it may be short
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         main_counter_q <= `TCC_RST16;
      else if (test_mode && wr_at(`TCC_IDX_CNT_HI))
         main_counter_q <= hwdata[15:0];
      else if (test_mode && wr_at(`TCC_IDX_CNT_LO))
         main_counter_q <= {main_counter_q[15:8], hwdata[7:0]};
      else if (cnt_run)
         main_counter_q <= main_counter_q + 16'h0001;
   end

   // ------------------------------------------------------------
   // compare and capture events
   // ------------------------------------------------------------
   tcc_pkg::tcc_chan_t oc_hit;
   tcc_pkg::tcc_chan_t ic_evt;
   logic               ovf_evt;

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         // select 1 compares, 0 captures
         oc_hit[i] = channel_function_select_q[i] && cnt_run
                     && (chan_val_q[i] == main_counter_q);
         ic_evt[i] = !channel_function_select_q[i] && tim_active
                     && pin_s2_q[i] && !pin_prev_q[i];
      end
   end

   assign ovf_evt = cnt_run && (main_counter_q == `TCC_CNT_MAX);

   // channel value registers; writes ignored on capture channels
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < 8; i++)
            chan_val_q[i] <= `TCC_RST16;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (ic_evt[i])
               chan_val_q[i] <= main_counter_q;
            else if (wr_now && dp_idx_q[5:4] == `TCC_CH_REGION
                     && dp_idx_q[3:1] == 3'(i)
                     && channel_function_select_q[i])
            begin
               if (dp_idx_q[0])
                  chan_val_q[i][7:0] <= hwdata[7:0];
               else
                  chan_val_q[i] <= hwdata[15:0];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         channel_function_select_q <= `TCC_RST8;
         ch7_override_mask_q       <= `TCC_RST8;
         ch7_override_data_q       <= `TCC_RST8;
         ctrl1_q                   <= 4'h0;
         irq_enable_q              <= 11'h000;
      end
      else
      begin
         if (wr_at(`TCC_IDX_CHSEL))
            channel_function_select_q <= hwdata[7:0];
         if (wr_at(`TCC_IDX_OVR_MASK))
            ch7_override_mask_q <= hwdata[7:0];
         if (wr_at(`TCC_IDX_OVR_DATA))
            ch7_override_data_q <= hwdata[7:0];
         if (wr_at(`TCC_IDX_CTRL1))
            ctrl1_q <= hwdata[7:4];
         if (wr_at(`TCC_IDX_IRQ_EN))
            irq_enable_q <= hwdata[10:0];
      end
   end

   // ------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------
   tcc_pkg::tcc_chan_t ch_clr;
   tcc_pkg::tcc_chan_t ch_fast;
   tcc_pkg::tcc_stat_t irq_clr;
   logic               ovf_clr;
   logic               pa_ovf_clr;
   logic               pa_in_clr;
   logic               cnt_access;
   logic               pa_access;

   assign irq_clr = wr_at(`TCC_IDX_IRQ_CLR) ? hwdata[10:0] : 11'h000;

   // counter and pulse count accesses, read or write, at address phase
   assign cnt_access = addr_take && (addr_idx == `TCC_IDX_CNT_HI
                                  || addr_idx == `TCC_IDX_CNT_LO);
   assign pa_access  = addr_take && (addr_idx == `TCC_IDX_PULSE_ACCUM_COUNT_HI
                                  || addr_idx == `TCC_IDX_PULSE_ACCUM_COUNT_LO);

   // reads clear capture flags, writes clear compare flags
   always_comb
   begin
      ch_fast = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         if (rd_take && addr_idx[5:4] == `TCC_CH_REGION
             && addr_idx[3:1] == 3'(i) && !channel_function_select_q[i])
            ch_fast[i] = 1'b1;
         if (wr_now && dp_idx_q[5:4] == `TCC_CH_REGION
             && dp_idx_q[3:1] == 3'(i) && channel_function_select_q[i])
            ch_fast[i] = 1'b1;
      end
   end

   // normal clearing is write-one-to-clear; fast paths only if enabled
   assign ch_clr = (wr_at(`TCC_IDX_CHFLAG) ? hwdata[7:0] : 8'h00)
                   | irq_clr[7:0]
                   | (fast_flag_clear ? ch_fast : 8'h00);
   assign ovf_clr = (wr_at(`TCC_IDX_OVFLAG) && hwdata[`TCC_OVF_BIT])
                    || irq_clr[`TCC_ST_OVF]
                    || (fast_flag_clear && cnt_access);
   assign pa_ovf_clr = (wr_at(`TCC_IDX_PAFLAG) && hwdata[`TCC_PA_OVF_BIT])
                       || irq_clr[`TCC_ST_PA_OVF]
                       || (fast_flag_clear && pa_access);
   assign pa_in_clr = (wr_at(`TCC_IDX_PAFLAG) && hwdata[`TCC_PA_IN_BIT])
                      || irq_clr[`TCC_ST_PA_IN]
                      || (fast_flag_clear && pa_access);

   // a new event in the clearing cycle survives: set beats clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         channel_event_flag_q        <= `TCC_RST8;
         counter_overflow_flag_q     <= 1'b0;
         pulse_accum_overflow_flag_q <= 1'b0;
         pulse_accum_input_flag_q    <= 1'b0;
      end
      else
      begin
         channel_event_flag_q <= (channel_event_flag_q & ~ch_clr)
                                 | oc_hit | ic_evt;
         counter_overflow_flag_q <= (counter_overflow_flag_q && !ovf_clr)
                                    || ovf_evt;
         pulse_accum_overflow_flag_q <= (pulse_accum_overflow_flag_q
                                         && !pa_ovf_clr) || pa_overflow_evt;
         pulse_accum_input_flag_q <= (pulse_accum_input_flag_q
                                      && !pa_in_clr) || pa_input_evt;
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   tcc_pkg::tcc_stat_t irq_status;

   assign irq_status = {pulse_accum_input_flag_q,
                        pulse_accum_overflow_flag_q,
                        counter_overflow_flag_q,
                        channel_event_flag_q};
   assign timer_irq  = |(irq_status & irq_enable_q);

   // ------------------------------------------------------------
   // channel-7 override and port pins
   // ------------------------------------------------------------
   // only the override writes port data here, so a masked bit takes
   // the override value no matter what else compares this cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         port_data_q <= `TCC_RST8;
      else if (oc_hit[7])
         port_data_q <= (port_data_q & ~ch7_override_mask_q)
                        | (ch7_override_data_q & ch7_override_mask_q);
   end

   // masked pins follow the port data, i.e. the override value
   assign tim_pin_out = port_data_q;
   // channel 7 pin is never driven; its output enable is tied to 0
   assign tim_pin_oe  = {1'b0, ch7_override_mask_q[6:0]
                               & channel_function_select_q[6:0]};

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   logic [2:0]  rd_ch;

   assign rd_ch = addr_idx[3:1];

   // the whole counter comes in one word so the two halves agree
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (addr_idx)
         `TCC_IDX_CHSEL:     rd_mux[7:0] = channel_function_select_q;
         `TCC_IDX_OVR_MASK:  rd_mux[7:0] = ch7_override_mask_q;
         `TCC_IDX_OVR_DATA:  rd_mux[7:0] = ch7_override_data_q;
         `TCC_IDX_CNT_HI:    rd_mux[15:0] = main_counter_q;
         `TCC_IDX_CNT_LO:    rd_mux[7:0] = main_counter_q[7:0];
         `TCC_IDX_CTRL1:     rd_mux[7:4] = ctrl1_q;
         `TCC_IDX_CHFLAG:    rd_mux[7:0] = channel_event_flag_q;
         `TCC_IDX_OVFLAG:
            rd_mux[`TCC_OVF_BIT] = counter_overflow_flag_q;
         `TCC_IDX_PAFLAG:
            rd_mux[1:0] = {pulse_accum_overflow_flag_q,
                           pulse_accum_input_flag_q};
         `TCC_IDX_PULSE_ACCUM_COUNT_HI:  rd_mux[15:0] = pa_count;
         `TCC_IDX_PULSE_ACCUM_COUNT_LO:  rd_mux[7:0] = pa_count[7:0];
         `TCC_IDX_IRQ_STAT:  rd_mux[10:0] = irq_status;
         `TCC_IDX_IRQ_EN:    rd_mux[10:0] = irq_enable_q;
         `TCC_IDX_PORT_DATA: rd_mux[7:0] = port_data_q;
         default:
         begin
            if (addr_idx[5:4] == `TCC_CH_REGION)
            begin
               if (addr_idx[0])
                  rd_mux[7:0] = chan_val_q[rd_ch][7:0];
               else
                  rd_mux[15:0] = chan_val_q[rd_ch];
            end
         end
      endcase
   end

   // read data registered at the address phase, shown in data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= 32'h0000_0000;
      else if (rd_take)
         hrdata_q <= rd_mux;
   end

endmodule // tcc_top

// file: design/tcc_defs.svh
// register indices, field positions, reset values and counts of the timer
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ------------------------------------------------------------
// register indices (byte address = 4 * index)
// ------------------------------------------------------------
`define TCC_IDX_CHSEL      6'h00
`define TCC_IDX_OVR_MASK   6'h02
`define TCC_IDX_OVR_DATA   6'h03
`define TCC_IDX_CNT_HI     6'h04
`define TCC_IDX_CNT_LO     6'h05
`define TCC_IDX_CTRL1      6'h06
`define TCC_IDX_CHFLAG     6'h0E
`define TCC_IDX_OVFLAG     6'h0F
`define TCC_IDX_PAFLAG     6'h21
`define TCC_IDX_PULSE_ACCUM_COUNT_HI   6'h22
`define TCC_IDX_PULSE_ACCUM_COUNT_LO   6'h23
`define TCC_IDX_IRQ_STAT   6'h30
`define TCC_IDX_IRQ_CLR    6'h31
`define TCC_IDX_IRQ_EN     6'h32
`define TCC_IDX_PORT_DATA  6'h33
// channel registers occupy indices 0x10..0x1F
`define TCC_CH_REGION      2'h1

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TCC_RUN_EN_BIT     7
`define TCC_STOP_WAIT_BIT  6
`define TCC_STOP_FRZ_BIT   5
`define TCC_FAST_CLR_BIT   4
`define TCC_OVF_BIT        7
`define TCC_PA_OVF_BIT     1
`define TCC_PA_IN_BIT      0
// interrupt status layout
`define TCC_ST_OVF         8
`define TCC_ST_PA_OVF      9
`define TCC_ST_PA_IN       10
`define TCC_ST_W           11

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define TCC_RST8           8'h00
`define TCC_RST16          16'h0000
`define TCC_CNT_MAX        16'hFFFF
`define TCC_PA_DIV_TOP     6'h3F

`endif

// file: design/tcc_pkg.sv
// shared types of the timer control block
package tcc_pkg;
   typedef logic [7:0]  tcc_chan_t;
   typedef logic [15:0] tcc_count_t;
   typedef logic [5:0]  tcc_idx_t;
   typedef logic [10:0] tcc_stat_t;
endpackage : tcc_pkg

// file: design/tcc_prescaler.sv
// divide-by-64 prescaler feeding the pulse accumulator clock
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_prescaler
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic run,
   output logic      div64_tick
);

   logic [5:0] pre_q;

   // holds its phase while stopped so a restart resumes mid-period
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pre_q <= 6'h00;
      else if (run)
         pre_q <= pre_q + 6'h01;
   end

   // no tick at all while the timer is inactive
   assign div64_tick = run && (pre_q == `TCC_PA_DIV_TOP);

endmodule // tcc_prescaler

// file: bench/tcc_checker.sv
// port-level assertions of the timer control block
`timescale 1ns/1ps

module tcc_checker
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [7:0]  tim_pin_out,
   input wire logic [7:0]  tim_pin_oe,
   input wire logic        pa_div64_tick,
   input wire logic        pa_halt,
   input wire logic        timer_irq
);
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic       wr_w;
   logic       rd_w;
   logic [7:0] gap_q;
   assign wr_w = hsel & hready & htrans[1] & hwrite;
   assign rd_w = hsel & hready & htrans[1] & ~hwrite;
   // running cycles since the last tick; halt restarts the span
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         gap_q <= 8'h00;
      else if (pa_halt || pa_div64_tick)
         gap_q <= 8'h00;
      else
         gap_q <= gap_q + 8'h01;

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   sequence s_quiet;
      !pa_div64_tick [*8];
   endsequence
   sequence s_idle_out;
      pa_halt && tim_pin_oe == 8'h00 && tim_pin_out == 8'h00 && !timer_irq;
   endsequence
   property p_oe_top;   tim_pin_oe[7] == 1'b0; endproperty
   property p_oe_cause; !$stable(tim_pin_oe) |-> $past(wr_w, 2); endproperty
   property p_rd_cause; !$stable(hrdata) |-> $past(rd_w); endproperty
   property p_halt;     pa_halt |-> !pa_div64_tick; endproperty
   property p_gap;      pa_div64_tick |=> s_quiet; endproperty
   property p_due;      gap_q <= 8'h40; endproperty
   property p_rst;      $rose(hresetn) |-> s_idle_out; endproperty
   property p_bus;      hreadyout && !hresp; endproperty
   a_oe_top:   assert property (p_oe_top)   else $error("pin 7 driven");
   a_oe_cause: assert property (p_oe_cause) else $error("oe changed");
   a_rd_cause: assert property (p_rd_cause) else $error("hrdata moved");
   a_halt:     assert property (p_halt)     else $error("halt tick");
   a_gap:      assert property (p_gap)      else $error("tick early");
   a_due:      assert property (p_due)      else $error("tick late");
   a_rst:      assert property (p_rst)      else $error("reset outs");
   a_bus:      assert property (p_bus)      else $error("bus not okay");
endmodule // tcc_checker

bind tcc_top tcc_checker tcc_checker_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .tim_pin_out(tim_pin_out), .tim_pin_oe(tim_pin_oe),
   .pa_div64_tick(pa_div64_tick), .pa_halt(pa_halt), .timer_irq(timer_irq));

// file: bench/tcc_pa_model.sv
// pulse accumulator and pin-side stand-in for the timer block
`timescale 1ns/1ps

module tcc_pa_model
(
   input  wire logic        hclk,
   input  wire logic        pa_div64_tick,
   input  wire logic [7:0]  pin_out,
   input  wire logic [7:0]  pin_oe,
   input  wire logic [7:0]  pin_drive,
   input  wire logic        fire_ovf,
   input  wire logic        fire_in,
   output logic [15:0]      pa_count,
   output logic             pa_overflow_evt,
   output logic             pa_input_evt,
   output logic [7:0]       pin_in
);
   // ------------------------------------------------------------
   // accumulator and pins
   // ------------------------------------------------------------
   // gated mode: count moves only on the divide-by-64 tick
   always @(posedge hclk)
   begin
      if ($time == 0 || pa_count === 16'hxxxx)
         pa_count <= 16'h0000;
      else if (pa_div64_tick)
         pa_count <= pa_count + 16'h0001;
      pa_overflow_evt <= fire_ovf;
      pa_input_evt    <= fire_in;
   end
   // a driven pin shows the block's level, else the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drive);
endmodule // tcc_pa_model

// file: bench/test_tcc_top.sv
// self-checking testbench of the timer control block
`timescale 1ns/1ps

module test_tcc_top;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic        hready, hresp, test_mode = 1'b0, wait_mode = 1'b0;
   logic        freeze_mode = 1'b0, fire_ovf = 1'b0, fire_in = 1'b0;
   logic [7:0]  pin_in, pin_out, pin_oe, pin_drive = 8'h5A;
   logic [15:0] pa_count;
   logic        pa_ovf, pa_in, tick, pa_halt, irq, rd_ph = 1'b0;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   logic [31:0] dr;
   int          n_errors = 0, compares = 0;

   tcc_top tcc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .test_mode(test_mode), .wait_mode(wait_mode),
      .freeze_mode(freeze_mode), .tim_pin_in(pin_in), .tim_pin_out(pin_out),
      .tim_pin_oe(pin_oe), .pa_count(pa_count), .pa_overflow_evt(pa_ovf),
      .pa_input_evt(pa_in), .pa_div64_tick(tick), .pa_halt(pa_halt),
      .timer_irq(irq));
   tcc_pa_model tcc_pa_model_i (.hclk(hclk), .pa_div64_tick(tick),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_drive(pin_drive),
      .fire_ovf(fire_ovf), .fire_in(fire_in), .pa_count(pa_count),
      .pa_overflow_evt(pa_ovf), .pa_input_evt(pa_in), .pin_in(pin_in));

   // 40 MHz clock
   initial
   begin
      forever #12.5 hclk = ~hclk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // one single transfer; a read notes its masked expectation first
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d, input logic [31:0] x,
                       input logic [31:0] m);
      if (!w)
         exp_q.push_back({x, m});
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, 32'h0, 32'h0);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] x,
                     input logic [31:0] m);
      xfer(a, 1'b0, 32'h0, x, m);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // read data is compared at the edge that ends its data phase
   always @(posedge hclk)
   begin
      if (rd_ph && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         chk(hrdata & e[31:0], e[63:32]);
      end
      rd_ph = hresetn & hsel & htrans[1] & ~hwrite & hready;
   end

   // hang guard, well above the length of the run
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      finish_test();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(5047));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(32'h00, 32'h0, 32'hFF);
      rd(32'h08, 32'h0, 32'hFF);
      rd(32'h0C, 32'h0, 32'hFF);
      rd(32'h18, 32'h0, 32'hF0);
      wr(32'hFC, 32'hFFFFFFFF);
      rd(32'hFC, 32'h0, 32'hFFFFFFFF);
      $display("reset test done");
      wr(32'h10, 32'h1234);
      rd(32'h10, 32'h0, 32'hFFFF);
      test_mode <= 1'b1;
      wr(32'h10, 32'h1234);
      repeat (10) @(posedge hclk);
      rd(32'h10, 32'h1234, 32'hFFFF);
      wr(32'h18, 32'h80);
      rd(32'h10, 32'h1234, 32'hFFFF);
      rd(32'h10, 32'h1236, 32'hFFFF);
      $display("counter test done");
      freeze_mode <= 1'b1;
      wr(32'h18, 32'hA0);
      wr(32'h10, 32'h0100);
      rd(32'h10, 32'h0100, 32'hFFFF);
      rd(32'h10, 32'h0100, 32'hFFFF);
      #1 chk(32'(pa_halt), 32'h0);
      freeze_mode <= 1'b0;
      wait_mode <= 1'b1;
      wr(32'h18, 32'hC0);
      wr(32'h10, 32'h0200);
      rd(32'h10, 32'h0200, 32'hFFFF);
      rd(32'h10, 32'h0200, 32'hFFFF);
      #1 chk(32'(pa_halt), 32'h1);
      wait_mode <= 1'b0;
      #1 chk(32'(pa_halt), 32'h0);
      $display("mode test done");
      dr = $urandom & 32'hFF;
      wr(32'h0C, dr);
      rd(32'h0C, dr, 32'hFF);
      wr(32'h00, 32'h7E);
      wr(32'h08, 32'h8F);
      #1 chk(32'(pin_oe), 32'h0E);
      wr(32'h00, 32'hFF);
      wr(32'h0C, 32'h05);
      #1 chk(32'(pin_oe), 32'h0F);
      wr(32'h78, 32'h40);
      wr(32'h40, 32'h40);
      wr(32'h10, 32'h0);
      repeat (80) @(posedge hclk);
      #1 chk(32'(pin_out), 32'h05);
      rd(32'hCC, 32'h05, 32'hFF);
      rd(32'h38, 32'h80, 32'h80);
      wr(32'h78, 32'h40);
      rd(32'h38, 32'h80, 32'h80);
      wr(32'h38, 32'h80);
      rd(32'h38, 32'h0, 32'h80);
      wr(32'h08, 32'h81);
      wr(32'h0C, 32'hFA);
      wr(32'h10, 32'h0);
      repeat (80) @(posedge hclk);
      rd(32'hCC, 32'h84, 32'hFF);
      #1 chk(32'(pin_oe), 32'h01);
      wr(32'h18, 32'hD0);
      wr(32'h78, 32'h40);
      rd(32'h38, 32'h0, 32'h80);
      $display("override test done");
      wr(32'h10, 32'hFFF0);
      repeat (20) @(posedge hclk);
      rd(32'h3C, 32'h80, 32'h80);
      rd(32'h10, 32'h0, 32'h0);
      rd(32'h3C, 32'h0, 32'h80);
      wr(32'hC8, 32'h600);
      fire_ovf <= 1'b1;
      fire_in <= 1'b1;
      @(posedge hclk);
      fire_ovf <= 1'b0;
      fire_in <= 1'b0;
      repeat (3) @(posedge hclk);
      #1 chk(32'(irq), 32'h1);
      rd(32'h84, 32'h3, 32'h3);
      rd(32'hC0, 32'h600, 32'h600);
      wr(32'hC8, 32'h0);
      #1 chk(32'(irq), 32'h0);
      wr(32'hC8, 32'h600);
      rd(32'h88, 32'h0, 32'h0);
      #1 chk(32'(irq), 32'h0);
      rd(32'h84, 32'h0, 32'h3);
      wr(32'hC4, 32'h67E);
      rd(32'h38, 32'h0, 32'h7E);
      wr(32'h18, 32'h00);
      #1 chk(32'(pa_halt), 32'h1);
      repeat (70) @(posedge hclk);
      $display("flag test done");
      finish_test();
   end
endmodule // test_tcc_top
